// ===== rtl/pcr_top.sv
`timescale 1ns/1ps
`include "pcr_params.svh"
`default_nettype none

module pcr_top
  import pcr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PCR_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic brownout_detect,
  output logic brownout_irq,
  output logic [1:0] power_reduction_mode,
  input wire logic serial_control_reg_bit7_wr,
  input wire logic uart_mode_bit,
  input wire logic framing_error_flag,
  output logic uart_mode_bit_wr,
  output logic framing_error_flag_wr,
  output logic serial_control_reg_bit7_rdata,
  input wire logic timer1_overflow,
  input wire logic timer1_baud_src,
  output logic uart_baud_tick
);

  localparam logic [7:0] RST = `PCR_RESET_VAL;

  localparam pcr_state_s ST_RESET = '{
    baud_double: RST[`PCR_POS_BAUD_DBL],
    framing_error_location_sel: RST[`PCR_POS_FE_SEL],
    brownout_irq_enable: RST[`PCR_POS_BO_IRQ_EN],
    user_flag_one: RST[`PCR_POS_FLAG1],
    user_flag_zero: RST[`PCR_POS_FLAG0],
    power_reduction_mode_msb: RST[`PCR_POS_PMODE_MSB],
    power_reduction_mode_lsb: RST[`PCR_POS_PMODE_LSB],
    rdata: `PCR_RDATA_RESET,
    bod_meta: 1'b0,
    bod_sync: 1'b0,
    bo_irq: 1'b0
  };

  function automatic logic pcr_hit(input logic [`PCR_ADDR_W-1:0] addr);
    pcr_hit = (addr == `PCR_ADDR);
  endfunction

  // Reserved bit always reads back as zero
  function automatic logic [7:0] pcr_pack(input pcr_state_s s);
    logic [7:0] b;
    b = 8'h00;
    b[`PCR_POS_PMODE_LSB] = s.power_reduction_mode_lsb;
    b[`PCR_POS_PMODE_MSB] = s.power_reduction_mode_msb;
    b[`PCR_POS_FLAG0] = s.user_flag_zero;
    b[`PCR_POS_FLAG1] = s.user_flag_one;
    b[`PCR_POS_BO_IRQ_EN] = s.brownout_irq_enable;
    b[`PCR_POS_FE_SEL] = s.framing_error_location_sel;
    b[`PCR_POS_BAUD_DBL] = s.baud_double;
    pcr_pack = b;
  endfunction

  pcr_state_s st;
  pcr_state_s next_st;
  logic setup_phase;
  logic access_phase;
  logic reg_write;

  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  // Byte lane 0 carries the whole register; other lanes are don't care
  assign reg_write = access_phase && pwrite && pcr_hit(paddr) && pstrb[0];

  always_comb
  begin
    next_st = st;
    // Brownout comparator is asynchronous to pclk
    next_st.bod_meta = brownout_detect;
    next_st.bod_sync = st.bod_meta;
    if (reg_write)
    begin
      next_st.power_reduction_mode_lsb = pwdata[`PCR_POS_PMODE_LSB];
      next_st.power_reduction_mode_msb = pwdata[`PCR_POS_PMODE_MSB];
      next_st.user_flag_zero = pwdata[`PCR_POS_FLAG0];
      next_st.user_flag_one = pwdata[`PCR_POS_FLAG1];
      next_st.brownout_irq_enable = pwdata[`PCR_POS_BO_IRQ_EN];
      next_st.framing_error_location_sel = pwdata[`PCR_POS_FE_SEL];
      next_st.baud_double = pwdata[`PCR_POS_BAUD_DBL];
    end
    // Read data captured in setup so it comes from a flop in access
    if (setup_phase)
    begin
      if (pcr_hit(paddr) && !pwrite)
        next_st.rdata = {24'h000000, pcr_pack(st)};
      else
        next_st.rdata = `PCR_RDATA_RESET;
    end
    next_st.bo_irq = st.bod_sync && st.brownout_irq_enable;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= ST_RESET;
    else
      st <= next_st;
  end

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access_phase && !pcr_hit(paddr);
  assign prdata = st.rdata;

  assign brownout_irq = st.bo_irq;

  assign power_reduction_mode = {st.power_reduction_mode_msb, st.power_reduction_mode_lsb};

  assign uart_mode_bit_wr = serial_control_reg_bit7_wr && !st.framing_error_location_sel;
  assign framing_error_flag_wr = serial_control_reg_bit7_wr && st.framing_error_location_sel;
  // Read mux is combinational so the core sees bit 7 in its own read cycle
  assign serial_control_reg_bit7_rdata = st.framing_error_location_sel ? framing_error_flag : uart_mode_bit;

  pcr_baud_if baud_bus();

  assign baud_bus.overflow = timer1_overflow;
  assign baud_bus.baud_src = timer1_baud_src;
  assign baud_bus.double_rate = st.baud_double;
  assign uart_baud_tick = baud_bus.tick;

  pcr_baud u_baud
  (
    .pclk(pclk),
    .presetn(presetn),
    .bi(baud_bus.div)
  );

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_flag_store: assert property (reg_write |=> {st.user_flag_one, st.user_flag_zero} == $past(pwdata[3:2]))
    else $error("Flag bits did not take the written value");

  a_flag_hold: assert property (!reg_write |=> $stable({st.user_flag_one, st.user_flag_zero}))
    else $error("Flag bits changed without a write");

  a_irq_raise: assert property ((brownout_detect && st.brownout_irq_enable) [*3] ##1 st.brownout_irq_enable
    |-> brownout_irq)
    else $error("Enabled brownout did not raise the interrupt");

  a_irq_block: assert property (!st.brownout_irq_enable |=> !brownout_irq)
    else $error("Brownout interrupt raised while disabled");

  a_mode_route: assert property (!st.framing_error_location_sel && serial_control_reg_bit7_wr
    |-> uart_mode_bit_wr && !framing_error_flag_wr && serial_control_reg_bit7_rdata == uart_mode_bit)
    else $error("Bit 7 did not reach the UART mode bit");

  a_fe_route: assert property (st.framing_error_location_sel && serial_control_reg_bit7_wr
    |-> framing_error_flag_wr && !uart_mode_bit_wr && serial_control_reg_bit7_rdata == framing_error_flag)
    else $error("Bit 7 did not reach the framing error flag");

  a_dbl_select: assert property (reg_write |=> baud_bus.double_rate == $past(pwdata[7]))
    else $error("Baud doubling select not updated by write");

  a_half_path: assert property (timer1_baud_src && timer1_overflow && !st.baud_double
    ##1 (timer1_baud_src && timer1_overflow && !st.baud_double) [*1]
    |=> uart_baud_tick != $past(uart_baud_tick))
    else $error("Two halved overflows did not give exactly one baud tick");

  a_mode_store: assert property (reg_write |=> power_reduction_mode == $past(pwdata[1:0]))
    else $error("Power reduction mode not updated by write");

  a_read_back: assert property (setup_phase && pcr_hit(paddr) && !pwrite && !reg_write
    |=> prdata == {24'h000000, pcr_pack($past(st))})
    else $error("Read data does not match the register");

  a_bad_addr: assert property (access_phase && !pcr_hit(paddr) |-> pslverr)
    else $error("Unmapped access gave no error");

  // Bus side: stores, holds and refused accesses
  a_write_byte: assert property (reg_write
    |=> pcr_pack(st) == {$past(pwdata[7:6]), 1'b0, $past(pwdata[4:0])})
    else $error("Register byte does not match the write");

  a_enable_store: assert property (reg_write
    |=> st.brownout_irq_enable == $past(pwdata[`PCR_POS_BO_IRQ_EN]))
    else $error("Brownout enable not updated by write");

  a_sel_store: assert property (reg_write
    |=> st.framing_error_location_sel == $past(pwdata[`PCR_POS_FE_SEL]))
    else $error("Framing error selector not updated by write");

  a_mode_hold: assert property (!reg_write
    |=> $stable(power_reduction_mode))
    else $error("Power reduction mode changed without a write");

  a_cfg_hold: assert property (!reg_write
    |=> $stable({st.baud_double, st.framing_error_location_sel, st.brownout_irq_enable}))
    else $error("Control bits changed without a write");

  a_strobe_gate: assert property (access_phase && pwrite && !pstrb[0]
    |=> $stable(pcr_pack(st)))
    else $error("Write without byte lane 0 changed the register");

  a_miss_write: assert property (access_phase && pwrite && !pcr_hit(paddr)
    |=> $stable(pcr_pack(st)))
    else $error("Unmapped write changed the register");

  a_rdata_hold: assert property (!setup_phase
    |=> $stable(prdata))
    else $error("Read data changed outside a setup cycle");

  a_rdata_miss: assert property (setup_phase && (pwrite || !pcr_hit(paddr))
    |=> prdata == `PCR_RDATA_RESET)
    else $error("Read data not cleared for a write or unmapped access");

  a_rd_access: assert property (access_phase && !pwrite && pcr_hit(paddr)
    |-> prdata == {24'h000000, pcr_pack(st)})
    else $error("Read data not standing in the access cycle");

  a_bad_read: assert property (access_phase && !pwrite && !pcr_hit(paddr)
    |-> prdata == `PCR_RDATA_RESET)
    else $error("Unmapped read returned data");

  a_rdata_upper: assert property (prdata[31:8] == 24'h000000
    && !prdata[`PCR_POS_RESERVED])
    else $error("Unused read data bits not zero");

  a_err_only_bad: assert property (pslverr
    |-> access_phase && !pcr_hit(paddr))
    else $error("Error response on a mapped or idle cycle");

  // Side paths: brownout, serial bit 7 and baud clock
  a_irq_level: assert property (st.bod_sync && st.brownout_irq_enable
    |=> brownout_irq)
    else $error("Synchronised brownout with enable gave no interrupt");

  a_irq_source: assert property (brownout_irq
    |-> $past(st.bod_sync && st.brownout_irq_enable))
    else $error("Brownout interrupt without enabled detection");

  a_irq_clear: assert property (!st.bod_sync
    |=> !brownout_irq)
    else $error("Brownout interrupt stayed up after detection ended");

  a_sync_lag: assert property (brownout_irq
    |-> $past(brownout_detect, 3))
    else $error("Brownout interrupt not three cycles behind detection");

  a_mode_read: assert property (!st.framing_error_location_sel
    |-> serial_control_reg_bit7_rdata == uart_mode_bit)
    else $error("Bit 7 read did not show the UART mode bit");

  a_mode_wr_gate: assert property (st.framing_error_location_sel
    |-> !uart_mode_bit_wr)
    else $error("UART mode bit written while framing error selected");

  a_no_stray_wr: assert property (!serial_control_reg_bit7_wr
    |-> !uart_mode_bit_wr && !framing_error_flag_wr)
    else $error("Bit 7 write strobe without a core write");

  a_fe_read: assert property (st.framing_error_location_sel
    |-> serial_control_reg_bit7_rdata == framing_error_flag)
    else $error("Bit 7 read did not show the framing error flag");

  a_fe_wr_gate: assert property (!st.framing_error_location_sel
    |-> !framing_error_flag_wr)
    else $error("Framing error flag written while mode bit selected");

  a_dbl_every: assert property (timer1_baud_src && timer1_overflow && st.baud_double
    |=> uart_baud_tick)
    else $error("Doubled rate dropped an overflow at the pins");

  a_tick_source: assert property (uart_baud_tick
    |-> $past(timer1_baud_src && timer1_overflow))
    else $error("Baud tick without a sourced overflow");

  a_half_gap: assert property (uart_baud_tick && !st.baud_double && !$past(st.baud_double)
    |=> !uart_baud_tick)
    else $error("Halved rate gave two ticks in a row");

  c_write: cover property (reg_write);
  c_irq: cover property (!brownout_irq ##1 brownout_irq);
  c_fe_path: cover property (framing_error_flag_wr);
  c_read: cover property (setup_phase && !pwrite ##1 access_phase && prdata != 32'h0000_0000);

endmodule

`default_nettype wire

// ===== pkg/pcr_params.svh
`ifndef PCR_PARAMS_SVH
`define PCR_PARAMS_SVH

// Register index and byte address on the APB side
`define PCR_INDEX 10'h087
`define PCR_ADDR {`PCR_INDEX, 2'b00}
`define PCR_ADDR_W 12

// Field positions inside the power control byte
`define PCR_POS_PMODE_LSB 0
`define PCR_POS_PMODE_MSB 1
`define PCR_POS_FLAG0 2
`define PCR_POS_FLAG1 3
`define PCR_POS_BO_IRQ_EN 4
`define PCR_POS_RESERVED 5
`define PCR_POS_FE_SEL 6
`define PCR_POS_BAUD_DBL 7

// Reset values
`define PCR_RESET_VAL 8'h00
`define PCR_RDATA_RESET 32'h0000_0000

`endif

// ===== pkg/pcr_pkg.sv
`default_nettype none

package pcr_pkg;

  typedef struct packed {
    logic baud_double;
    logic framing_error_location_sel;
    logic brownout_irq_enable;
    logic user_flag_one;
    logic user_flag_zero;
    logic power_reduction_mode_msb;
    logic power_reduction_mode_lsb;
    logic [31:0] rdata;
    logic bod_meta;
    logic bod_sync;
    logic bo_irq;
  } pcr_state_s;

  typedef struct packed {
    logic half;
    logic tick;
  } pcr_baud_s;

endpackage

`default_nettype wire

// ===== pkg/pcr_baud_if.sv
`timescale 1ns/1ps
`default_nettype none

interface pcr_baud_if;
  logic overflow;
  logic baud_src;
  logic double_rate;
  logic tick;

  modport ctrl
  (
    output overflow,
    output baud_src,
    output double_rate,
    input tick
  );

  modport div
  (
    input overflow,
    input baud_src,
    input double_rate,
    output tick
  );
endinterface

`default_nettype wire

// ===== rtl/pcr_baud.sv
`timescale 1ns/1ps
`default_nettype none

module pcr_baud
  import pcr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  pcr_baud_if.div bi
);

  pcr_baud_s st;
  pcr_baud_s next_st;

  always_comb
  begin
    next_st = st;
    next_st.tick = 1'b0;
    if (bi.baud_src && bi.overflow)
    begin
      if (bi.double_rate)
        next_st.tick = 1'b1;
      else
      begin
        next_st.tick = st.half;
        next_st.half = ~st.half;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign bi.tick = st.tick;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_double_pass: assert property (bi.baud_src && bi.overflow && bi.double_rate |=> bi.tick)
    else $error("Doubled baud rate dropped an overflow");
  a_half_skip: assert property (bi.baud_src && bi.overflow && !bi.double_rate && !st.half |=> !bi.tick)
    else $error("Halved baud rate passed the first overflow");
  a_half_pass: assert property (bi.baud_src && bi.overflow && !bi.double_rate && st.half |=> bi.tick)
    else $error("Halved baud rate lost the second overflow");
  a_no_source: assert property (!(bi.baud_src && bi.overflow) |=> !bi.tick)
    else $error("Baud tick without a timer overflow");

  c_half_tick: cover property (!bi.double_rate ##0 bi.tick);

endmodule

`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/1ps
`include "pcr_params.svh"
`default_nettype none

module tb_top
  import pcr_pkg::*;
;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [3:0] s; logic e; logic [7:0] v;} pcr_row_s;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] pstrb = 0;
  logic pready, pslverr, brownout_detect = 0, brownout_irq, serial_control_reg_bit7_wr = 0, uart_mode_bit = 0;
  logic framing_error_flag = 0, uart_mode_bit_wr, framing_error_flag_wr, serial_control_reg_bit7_rdata;
  logic timer1_overflow = 0, timer1_baud_src = 0, uart_baud_tick, err;
  logic [1:0] power_reduction_mode;
  int n_errors = 0, checked = 0, ticks;
  pcr_row_s rows[6] = '{
    '{`PCR_ADDR, 32'h0000_00FF, 4'h1, 1'b0, 8'hDF},
    '{`PCR_ADDR, 32'h0000_000C, 4'hF, 1'b0, 8'h0C},
    '{12'h000, 32'h0000_00FF, 4'hF, 1'b1, 8'h0C},
    '{`PCR_ADDR, 32'h0000_0033, 4'hE, 1'b0, 8'h0C},
    '{`PCR_ADDR, 32'hFFFF_FF23, 4'h1, 1'b0, 8'h03},
    '{12'h220, 32'h0000_0000, 4'hF, 1'b1, 8'h03}};

  pcr_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .brownout_detect(brownout_detect), .brownout_irq(brownout_irq),
    .power_reduction_mode(power_reduction_mode), .serial_control_reg_bit7_wr(serial_control_reg_bit7_wr),
    .uart_mode_bit(uart_mode_bit), .framing_error_flag(framing_error_flag),
    .uart_mode_bit_wr(uart_mode_bit_wr), .framing_error_flag_wr(framing_error_flag_wr),
    .serial_control_reg_bit7_rdata(serial_control_reg_bit7_rdata), .timer1_overflow(timer1_overflow),
    .timer1_baud_src(timer1_baud_src), .uart_baud_tick(uart_baud_tick));

  initial
  begin
    forever #10 pclk = ~pclk;
  end

  task report_and_stop;
    $display("Errors %0d, comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Idle cycle first, so back-to-back calls never drive psel twice in one step
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task ovf;
    @(posedge pclk);
    timer1_overflow <= 1'b1;
    @(posedge pclk);
    timer1_overflow <= 1'b0;
    #1;
    if (uart_baud_tick === 1'b1)
      ticks++;
  endtask

  task count_ticks(input logic [7:0] v, input logic src, input int n, input int exp);
    apb(1'b1, `PCR_ADDR, {24'h0, v}, 4'hF);
    timer1_baud_src <= src;
    ticks = 0;
    repeat (n) ovf();
    check(ticks, exp);
  endtask

  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    check(power_reduction_mode, 2'b00);
    apb(1'b0, `PCR_ADDR, 32'h0, 4'hF);
    check(rd, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, rows[i].a, rows[i].d, rows[i].s);
      check(err, rows[i].e);
      apb(1'b0, `PCR_ADDR, 32'h0, 4'hF);
      check(rd, {24'h0, rows[i].v});
      check(power_reduction_mode, rows[i].v[1:0]);
    end
    apb(1'b0, 12'h004, 32'h0, 4'hF);
    check({err, rd}, {1'b1, 32'h0});
    // Brownout blocked while enable is clear
    brownout_detect <= 1'b1;
    repeat (4) @(posedge pclk);
    #1;
    check(brownout_irq, 1'b0);
    apb(1'b1, `PCR_ADDR, 32'h10, 4'hF);
    @(posedge pclk);
    #1;
    check(brownout_irq, 1'b1);
    apb(1'b1, `PCR_ADDR, 32'h00, 4'hF);
    @(posedge pclk);
    #1;
    check(brownout_irq, 1'b0);
    brownout_detect <= 1'b0;
    // Serial bit 7 routing, both selector values
    @(posedge pclk);
    serial_control_reg_bit7_wr <= 1'b1;
    uart_mode_bit <= 1'b1;
    #1;
    check({uart_mode_bit_wr, framing_error_flag_wr, serial_control_reg_bit7_rdata}, 3'b101);
    apb(1'b1, `PCR_ADDR, 32'h40, 4'hF);
    #1;
    check({uart_mode_bit_wr, framing_error_flag_wr, serial_control_reg_bit7_rdata}, 3'b010);
    @(posedge pclk);
    framing_error_flag <= 1'b1;
    #1;
    check(serial_control_reg_bit7_rdata, 1'b1);
    @(posedge pclk);
    serial_control_reg_bit7_wr <= 1'b0;
    count_ticks(8'h80, 1'b1, 4, 4);
    count_ticks(8'h00, 1'b1, 4, 2);
    count_ticks(8'h80, 1'b0, 2, 0);
    // Back-to-back halved overflows give exactly one tick
    apb(1'b1, `PCR_ADDR, 32'h0, 4'hF);
    timer1_baud_src <= 1'b1;
    timer1_overflow <= 1'b1;
    @(posedge pclk);
    #1;
    check(uart_baud_tick, 1'b0);
    @(posedge pclk);
    timer1_overflow <= 1'b0;
    #1;
    check(uart_baud_tick, 1'b1);
    // Mid-run reset clears the register
    apb(1'b1, `PCR_ADDR, 32'h0000_008F, 4'hF);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    check(power_reduction_mode, 2'b00);
    apb(1'b0, `PCR_ADDR, 32'h0, 4'hF);
    check(rd, 32'h0);
    report_and_stop();
  end

  // Whole run needs well under 1000 cycles
  initial
  begin
    repeat (5000) @(posedge pclk);
    n_errors++;
    report_and_stop();
  end
endmodule

`default_nettype wire
